//--- rtl/vrm_device.sv
// Purpose: i2c slave with three-register mailbox and virtual register side
// Assumes: scl and sda already synchronous to clk_i
// Notes:   virtual side is a small register array; results arrive by strobe
`timescale 1ns/1ps
module vrm_device
	import vrm_pkg::*;
(
	input  wire logic        clk_i,        // master clock
	input  wire logic        reset_i,      // synchronous, active high
	input  wire logic        ext_reset_n_i,// external reset pin
	vrm_if.dev               bus,          // i2c wires
	input  wire logic        conv_done_i,  // integration finished pulse
	input  wire logic [95:0] conv_res_i,   // x,y,z results, big endian
	input  wire logic        dir_rdy_i,    // director target ready pulse
	output logic             int_n_o       // active-low interrupt
);
	typedef enum logic [2:0] {
		VRM_IDLE = 3'b000, VRM_ADDR = 3'b001, VRM_RX = 3'b010,
		VRM_TX = 3'b011, VRM_ACK = 3'b100, VRM_RACK = 3'b101
	} vrm_st_t;
	vrm_st_t     st_q;                   // slave state
	logic [7:0]  sh_q;                   // shift register
	logic [3:0]  bit_q;                  // bit counter
	logic        rd_q;                   // current transfer is a read
	logic        first_q;                // next rx byte is register select
	logic [7:0]  sel_q;                  // selected physical register
	logic        scl_q, sda_q;           // previous line levels
	logic        oe_q;                   // sda pull-down
	logic [7:0]  wr_q;                   // write register
	logic        txv_q, rxv_q;           // status flags
	logic [7:0]  rdb_q;                  // read register
	logic        wpend_q;                // marked address awaits data
	logic [6:0]  vaddr_q;                // pending virtual write address
	logic [7:0]  vr_q [VRM_NREG];        // virtual registers
	logic [95:0] res_q;                  // readable result copy
	logic [95:0] shd_q;                  // frozen shadow
	logic        frz_q;                  // shadow in use
	logic        irq_q;                  // interrupt asserted
	logic [31:0] rcnt_q;                 // reset pin low counter
	logic        prst_q;                 // pin reset active

	// line events
	wire start_w = scl_q & bus.scl & sda_q & ~bus.sda;
	wire stop_w  = scl_q & bus.scl & ~sda_q & bus.sda;
	wire rise_w  = ~scl_q & bus.scl;
	wire fall_w  = scl_q & ~bus.scl;
	wire rst_w   = reset_i | prst_q;
	wire [7:0] byte_w = {sh_q[6:0], bus.sda};
	wire       done_w = rise_w & (bit_q == 4'd7) & (st_q == VRM_ADDR || st_q == VRM_RX);
	wire       hit_w  = byte_w[7:1] == VRM_SLAVE_ADDR;
	// every rx byte after the register select of a write is data
	wire       wdat_w = done_w & (st_q == VRM_RX) & ~first_q;
	wire       wreg_w = wdat_w & (sel_q == VRM_REG_WRITE);
	// read byte is loaded as the read-address ack slot ends
	wire       rload_w = (st_q == VRM_ACK) & fall_w & rd_q & (bit_q == 4'd9);
	wire [7:0] stat_w = {6'h00, txv_q, rxv_q};
	wire [7:0] out_w = (sel_q == VRM_REG_STATUS) ? stat_w : (sel_q == VRM_REG_READ) ? rdb_q : 8'hFF;
	wire       rdreg_w = rload_w & (sel_q == VRM_REG_READ);
	wire       isw_w  = wr_q[VRM_BIT_WMARK];
	wire [6:0] va_w   = wr_q[6:0];
	wire [95:0] rsrc_w = frz_q ? shd_q : res_q;
	wire [6:0]  roff_w = va_w - VRM_VREG_RES_LO;
	wire        isres_w = (va_w >= VRM_VREG_RES_LO) && (va_w <= VRM_VREG_RES_HI);
	wire [7:0]  rbyte_w = rsrc_w[95 - 8*roff_w -: 8];
	wire        vrd_w  = txv_q & ~wpend_q & ~isw_w & ~rxv_q;
	wire        vwr_w  = txv_q & wpend_q;
	wire        vaw_w  = txv_q & ~wpend_q & isw_w;
	wire [7:0]  conv_w = vr_q[VRM_VREG_CONV];
	wire [7:0]  dirc_w = vr_q[VRM_VREG_DIR];

	always_ff @(posedge clk_i) begin
		if (reset_i || ext_reset_n_i) begin
			rcnt_q <= 32'h0;
			prst_q <= 1'b0;
		end else if (rcnt_q >= 32'(VRM_RST_CYC)) begin
			prst_q <= 1'b1;
		end else begin
			rcnt_q <= rcnt_q + 32'h1;
		end
	end

	// i2c bit engine
	// every register runs on the one master clock
	always_ff @(posedge clk_i) begin
		scl_q <= bus.scl;
		sda_q <= bus.sda;
		if (rst_w || stop_w) begin
			st_q <= VRM_IDLE;
			oe_q <= 1'b0;
			bit_q <= 4'h0;
			rd_q <= 1'b0;
			first_q <= 1'b1;
			if (rst_w) sel_q <= VRM_REG_STATUS;
		end else if (start_w) begin
			st_q <= VRM_ADDR;
			bit_q <= 4'h0;
			oe_q <= 1'b0;
			first_q <= 1'b1;
		end else begin
			// only received bits shift in; transmit keeps its own byte
			if (rise_w && (st_q == VRM_ADDR || st_q == VRM_RX)) begin
				sh_q <= byte_w;
				bit_q <= bit_q + 4'h1;
			end
			if (done_w && st_q == VRM_ADDR) begin
				rd_q <= byte_w[0];
				st_q <= hit_w ? VRM_ACK : VRM_IDLE;
			end else if (done_w) begin
				st_q <= VRM_ACK;
				if (first_q) sel_q <= byte_w;
				first_q <= 1'b0;
			end
			if (fall_w) begin
				case (st_q)
					VRM_ACK: begin
						if (bit_q == 4'd8) begin
							// drive the ack for the whole ninth clock
							oe_q <= 1'b1;
							bit_q <= 4'h9;
						end else if (rd_q) begin
							// ack done: first data bit of the read byte
							st_q <= VRM_TX;
							sh_q <= out_w;
							oe_q <= ~out_w[7];
							bit_q <= 4'h1;
						end else begin
							oe_q <= 1'b0;
							st_q <= VRM_RX;
							bit_q <= 4'h0;
						end
					end
					VRM_TX: begin
						if (bit_q == 4'd8) begin
							oe_q <= 1'b0;
							st_q <= VRM_RACK;
						end else begin
							oe_q <= ~sh_q[7 - bit_q[2:0]];
							bit_q <= bit_q + 4'h1;
						end
					end
					default: oe_q <= 1'b0;
				endcase
			end
			if (rise_w && st_q == VRM_RACK) begin
				st_q <= bus.sda ? VRM_IDLE : VRM_RACK;
			end
		end
	end
	assign bus.sda_d_oe = oe_q;

	// mailbox flags and virtual side
	always_ff @(posedge clk_i) begin
		if (rst_w) begin
			txv_q <= 1'b0;
			rxv_q <= 1'b0;
			wr_q <= 8'h00;
			rdb_q <= 8'h00;
			wpend_q <= 1'b0;
			vaddr_q <= 7'h00;
			frz_q <= 1'b0;
			res_q <= 96'h0;
			shd_q <= 96'h0;
			irq_q <= 1'b0;
			for (int i = 0; i < VRM_NREG; i++) vr_q[i] <= 8'h00;
		end else begin
			// whole result copy at integration end
			if (conv_done_i) res_q <= conv_res_i;
			if (conv_done_i && conv_w[VRM_CONV_RDYINT]) begin
				vr_q[VRM_VREG_CONV][VRM_CONV_DRDY] <= 1'b1;
			end
			if (dir_rdy_i && dirc_w[VRM_DIR_PWMINT]) begin
				vr_q[VRM_VREG_DIR][VRM_DIR_PRDY] <= 1'b1;
			end
			if (wreg_w) begin
				wr_q <= byte_w;
				txv_q <= 1'b1;
			end
			if (rdreg_w) rxv_q <= 1'b0;
			// marked address: remember, free the slot
			if (vaw_w) begin
				vaddr_q <= va_w;
				wpend_q <= 1'b1;
				txv_q <= 1'b0;
			end
			if (vwr_w) begin
				vr_q[vaddr_q] <= wr_q;
				wpend_q <= 1'b0;
				txv_q <= 1'b0;
			end
			if (vrd_w) begin
				txv_q <= 1'b0;
				rxv_q <= 1'b1;
				rdb_q <= isres_w ? rbyte_w : vr_q[va_w];
				if ((va_w == VRM_VREG_CONV && !dir_w()) || va_w == VRM_VREG_DIR) irq_q <= 1'b0;
				if (isres_w && !(conv_done_i && conv_w[VRM_CONV_RDYINT])) begin
					vr_q[VRM_VREG_CONV][VRM_CONV_DRDY] <= 1'b0;
				end
				// freeze on first byte of a value, thaw on last
				if (isres_w && roff_w[1:0] == 2'b00) begin
					frz_q <= 1'b1;
					shd_q <= res_q;
				end else if (isres_w && roff_w[1:0] == 2'b11) begin
					frz_q <= 1'b0;
				end
			end
			if ((conv_done_i && conv_w[VRM_CONV_RDYINT]) || (dir_rdy_i && dirc_w[VRM_DIR_PWMINT])) begin
				irq_q <= 1'b1;
			end
		end
	end
	function automatic logic dir_w();
		return 1'b0;
	endfunction
	assign int_n_o = ~irq_q;
endmodule

//--- rtl/vrm_host.sv
// Purpose: i2c master that runs mailbox virtual reads and writes
// Assumes: single device on the bus
// Notes:   user issues one virtual access at a time
`timescale 1ns/1ps
module vrm_host
	import vrm_pkg::*;
(
	input  wire logic       clk_i,     // master clock
	input  wire logic       reset_i,   // synchronous, active high
	vrm_if.host             bus,       // i2c wires
	input  wire logic       fast_i,    // 1 selects 400 kHz
	input  wire logic       req_i,     // start a virtual access
	input  wire logic       wr_i,      // 1 write, 0 read
	input  wire logic [6:0] vaddr_i,   // virtual address
	input  wire logic [7:0] wdata_i,   // write data
	output logic            busy_o,    // access in progress
	output logic            done_o,    // one-cycle completion
	output logic [7:0]      rdata_o,   // read result
	output logic            nack_o     // device did not acknowledge a write-slot poll
);
	typedef enum logic [3:0] {
		HS_IDLE = 4'b0000, HS_POLLW = 4'b0001, HS_SADDR = 4'b0010, HS_POLLW2 = 4'b0011,
		HS_SDATA = 4'b0100, HS_POLLR = 4'b0101, HS_GETR = 4'b0110, HS_FIN = 4'b0111
	} hs_st_t;
	typedef enum logic [2:0] {
		BT_IDLE = 3'b000, BT_START = 3'b001, BT_BYTE = 3'b010, BT_STOP = 3'b011, BT_DONE = 3'b100,
		BT_RSTART = 3'b101
	} bt_st_t;
	hs_st_t      st_q;             // access sequencer
	bt_st_t      bt_q;             // bus transaction
	logic [15:0] div_q;            // phase timer, a quarter of the scl period
	logic [1:0]  ph_q;             // quarter within a bit
	logic [3:0]  bit_q;            // bit index
	logic [2:0]  byt_q;            // byte index in transaction
	logic [7:0]  b_q [4];          // bytes to send
	logic [2:0]  nb_q;             // byte count
	logic        rd_q;             // transaction reads last byte
	logic [7:0]  rx_q;             // received byte
	logic        sclo_q, sdao_q;   // line drive
	logic        wr_q;             // latched request
	logic [6:0]  va_q;
	logic [7:0]  wd_q;
	logic        nk_q, go_q;
	// four phases per scl period, so each phase is half of a half period
	wire [15:0] half_w = fast_i ? 16'(VRM_HALF_FAST / 2) : 16'(VRM_HALF_STD / 2);
	wire        tick_w = div_q == 16'h0;
	wire        last_w = byt_q == nb_q - 3'd1;

	// one bus transaction: start, bytes, optional read, stop
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			bt_q <= BT_IDLE; div_q <= 16'h0; ph_q <= 2'd0; bit_q <= 4'h0; byt_q <= 3'd0;
			sclo_q <= 1'b1; sdao_q <= 1'b1; rx_q <= 8'h00; nk_q <= 1'b0;
		end else if (bt_q == BT_IDLE || bt_q == BT_DONE) begin
			bt_q <= go_q ? BT_START : BT_IDLE;
			div_q <= half_w;
			ph_q <= 2'd0;
		end else if (!tick_w) begin
			div_q <= div_q - 16'h1;
		end else begin
			div_q <= half_w;
			case (bt_q)
				BT_START: begin
					sdao_q <= 1'b0;
					bt_q <= BT_BYTE; bit_q <= 4'h0; byt_q <= 3'd0; ph_q <= 2'd0; nk_q <= 1'b0;
				end
				BT_BYTE: begin
					ph_q <= ph_q + 2'd1;
					if (ph_q == 2'd0) begin
						sclo_q <= 1'b0;
					end else if (ph_q == 2'd1) begin
						if (bit_q < 4'd8) sdao_q <= (rd_q && last_w) ? 1'b1 : b_q[byt_q[1:0]][3'd7 - bit_q[2:0]];
						// release for the device ack, or nack the single read byte
						else sdao_q <= 1'b1;
					end else if (ph_q == 2'd2) begin
						sclo_q <= 1'b1;
					end else begin
						if (bit_q < 4'd8) rx_q <= {rx_q[6:0], bus.sda};
						else if (!(rd_q && last_w) && bus.sda) nk_q <= 1'b1;
						if (bit_q == 4'd8) begin
							bit_q <= 4'h0;
							byt_q <= byt_q + 3'd1;
							if (last_w) bt_q <= BT_STOP;
							else if (rd_q && byt_q == 3'd1) bt_q <= BT_RSTART;
						end else begin
							bit_q <= bit_q + 4'h1;
						end
					end
				end
				// repeated start between register select and the read address
				BT_RSTART: begin
					ph_q <= ph_q + 2'd1;
					if (ph_q == 2'd0) sclo_q <= 1'b0;
					else if (ph_q == 2'd1) sdao_q <= 1'b1;
					else if (ph_q == 2'd2) sclo_q <= 1'b1;
					else begin
						sdao_q <= 1'b0;
						bt_q <= BT_BYTE;
					end
				end
				BT_STOP: begin
					ph_q <= ph_q + 2'd1;
					if (ph_q == 2'd0) sclo_q <= 1'b0;
					else if (ph_q == 2'd1) sdao_q <= 1'b0;
					else if (ph_q == 2'd2) sclo_q <= 1'b1;
					else begin
						sdao_q <= 1'b1;
						bt_q <= BT_DONE;
					end
				end
				default: bt_q <= BT_IDLE;
			endcase
		end
	end
	assign bus.scl_o    = sclo_q;
	assign bus.scl_oe   = ~sclo_q;
	assign bus.sda_h_oe = ~sdao_q;

	wire bdone_w = bt_q == BT_DONE;
	wire [7:0] st_w = rx_q;
	// access sequencer: each step is one transaction
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			st_q <= HS_IDLE; go_q <= 1'b0; nb_q <= 3'd0; rd_q <= 1'b0; done_o <= 1'b0;
			rdata_o <= 8'h00; nack_o <= 1'b0; wr_q <= 1'b0; va_q <= 7'h00; wd_q <= 8'h00;
			for (int i = 0; i < 4; i++) b_q[i] <= 8'h00;
		end else begin
			done_o <= 1'b0;
			go_q <= 1'b0;
			case (st_q)
				HS_IDLE: if (req_i) begin
					wr_q <= wr_i; va_q <= vaddr_i; wd_q <= wdata_i; nack_o <= 1'b0;
					st_q <= HS_POLLW;
					b_q[0] <= VRM_ADDR_WR; b_q[1] <= VRM_REG_STATUS; b_q[2] <= VRM_ADDR_RD;
					nb_q <= 3'd4; rd_q <= 1'b1; go_q <= 1'b1;
				end
				HS_POLLW, HS_POLLW2: if (bdone_w) begin
					nack_o <= nk_q;
					if (st_w[VRM_BIT_TXV]) begin
						go_q <= 1'b1;
					end else begin
						st_q <= (st_q == HS_POLLW) ? HS_SADDR : HS_SDATA;
						b_q[1] <= VRM_REG_WRITE;
						b_q[2] <= (st_q == HS_POLLW) ? (wr_q ? ({1'b0, va_q} | VRM_WMARK) : {1'b0, va_q}) : wd_q;
						nb_q <= 3'd3; rd_q <= 1'b0; go_q <= 1'b1;
					end
				end
				HS_SADDR: if (bdone_w) begin
					b_q[1] <= VRM_REG_STATUS; b_q[2] <= VRM_ADDR_RD; rd_q <= 1'b1; go_q <= 1'b1;
					nb_q <= 3'd4;
					st_q <= wr_q ? HS_POLLW2 : HS_POLLR;
				end
				HS_SDATA: if (bdone_w) st_q <= HS_FIN;
				HS_POLLR: if (bdone_w) begin
					if (st_w[VRM_BIT_RXV]) begin
						b_q[1] <= VRM_REG_READ; st_q <= HS_GETR;
					end
					go_q <= 1'b1;
				end
				HS_GETR: if (bdone_w) begin
					rdata_o <= rx_q; st_q <= HS_FIN;
				end
				HS_FIN: begin
					done_o <= 1'b1; st_q <= HS_IDLE;
				end
				default: st_q <= HS_IDLE;
			endcase
		end
	end
	assign busy_o = st_q != HS_IDLE;
endmodule

//--- rtl/vrm_if.sv
// Purpose: i2c wires between host and device ends
// Assumes: open drain, pulled high when nobody drives
// Notes:   resolves wire levels from the enables
`timescale 1ns/1ps
interface vrm_if;
	logic scl_o;     // host drives scl low when scl_oe
	logic scl_oe;    // host scl enable
	logic sda_h_oe;  // host pulls sda low
	logic sda_d_oe;  // device pulls sda low
	logic scl;       // resolved scl
	logic sda;       // resolved sda
	assign scl = ~(scl_oe & ~scl_o);
	assign sda = ~(sda_h_oe | sda_d_oe);
	modport dev  (input scl, input sda, output sda_d_oe);
	modport host (input scl, input sda, output scl_o, output scl_oe, output sda_h_oe);
endinterface

//--- rtl/vrm_pkg.sv
// Purpose: shared constants for the i2c virtual register mailbox
// Assumes: one 250 MHz clock on both ends; scl driven only by the host end
// Notes:   physical registers sit at their printed offsets
package vrm_pkg;
	localparam logic [6:0] VRM_SLAVE_ADDR    = 7'h49;   // 7-bit slave address
	localparam logic [7:0] VRM_ADDR_WR       = 8'h92;   // address byte, master write
	localparam logic [7:0] VRM_ADDR_RD       = 8'h93;   // address byte, master read
	localparam logic [7:0] VRM_REG_STATUS    = 8'h00;   // status, read only
	localparam logic [7:0] VRM_REG_WRITE     = 8'h01;   // write byte, write only
	localparam logic [7:0] VRM_REG_READ      = 8'h02;   // read byte, read only
	localparam int         VRM_BIT_RXV       = 0;       // read byte ready
	localparam int         VRM_BIT_TXV       = 1;       // write slot full
	localparam int         VRM_BIT_WMARK     = 7;       // pending-write marker
	localparam logic [7:0] VRM_WMARK         = 8'h80;   // marker mask
	localparam logic [6:0] VRM_VREG_CONV     = 7'h04;   // conversion control
	localparam logic [6:0] VRM_VREG_DIR      = 7'h64;   // director control
	localparam logic [6:0] VRM_VREG_RES_LO   = 7'h14;   // first result byte
	localparam logic [6:0] VRM_VREG_RES_HI   = 7'h1F;   // last result byte
	localparam int         VRM_CONV_RDYINT   = 6;       // conversion irq enable
	localparam int         VRM_CONV_DRDY     = 1;       // conversion ready flag
	localparam int         VRM_DIR_PWMINT    = 4;       // director irq enable
	localparam int         VRM_DIR_PRDY      = 0;       // director ready flag
	localparam int         VRM_CLK_MHZ       = 250;     // system clock
	localparam int         VRM_OSC_MHZ       = 16;      // documented master oscillator
	localparam int         VRM_RST_MS        = 100;     // least reset pin low time
	localparam int         VRM_RST_CYC       = VRM_RST_MS * 1000 * VRM_CLK_MHZ; // ms to us, then cycles per us
	localparam int         VRM_SCL_STD_KHZ   = 100;     // standard mode
	localparam int         VRM_SCL_FAST_KHZ  = 400;     // fast mode
	localparam int         VRM_HALF_STD      = (VRM_CLK_MHZ * 1000) / (2 * VRM_SCL_STD_KHZ);
	localparam int         VRM_HALF_FAST     = (VRM_CLK_MHZ * 1000) / (2 * VRM_SCL_FAST_KHZ);
	localparam int         VRM_RES_BYTES     = 12;      // x, y, z four bytes each
	localparam int         VRM_NREG          = 128;     // virtual register space
endpackage

//--- tb/test_i2c_virtual_register_mailbox.sv
// Purpose: host and device ends joined on one bus, driven from the host user side
// Assumes: polling accesses take tens of thousands of cycles each in fast mode, hundreds of thousands in standard mode
// Notes:   the external reset pin stays high; its 100 ms count is out of reach
`timescale 1ns/1ps
module test_i2c_virtual_register_mailbox;
	import vrm_pkg::*;
	localparam int WAIT_MAX = 600000;  // cycles for one access, standard mode included
	localparam int WATCH    = 9000000; // whole run limit
	logic        clk_i, reset_i, ext_reset_n_i, conv_done_i, dir_rdy_i;
	logic        fast_i, req_i, wr_i, int_n_o, busy_o, done_o, nack_o;
	logic [95:0] conv_res_i, res_a, res_b;
	logic [6:0]  vaddr_i, a;
	logic [7:0]  wdata_i, rdata_o, got, d;
	int          n_fail, checks_done;
	vrm_if bus_if ();
	vrm_device vrm_device_inst (.clk_i(clk_i), .reset_i(reset_i), .ext_reset_n_i(ext_reset_n_i),
		.bus(bus_if.dev), .conv_done_i(conv_done_i), .conv_res_i(conv_res_i),
		.dir_rdy_i(dir_rdy_i), .int_n_o(int_n_o));
	vrm_host vrm_host_inst (.clk_i(clk_i), .reset_i(reset_i), .bus(bus_if.host), .fast_i(fast_i),
		.req_i(req_i), .wr_i(wr_i), .vaddr_i(vaddr_i), .wdata_i(wdata_i), .busy_o(busy_o),
		.done_o(done_o), .rdata_o(rdata_o), .nack_o(nack_o));
	vrm_assertions vrm_assertions_inst (.clk_i(clk_i), .reset_i(reset_i), .scl_o(bus_if.scl_o),
		.scl_oe(bus_if.scl_oe), .sda_h_oe(bus_if.sda_h_oe), .sda_d_oe(bus_if.sda_d_oe),
		.scl(bus_if.scl), .sda(bus_if.sda));
	// free-running 250 MHz clock
	initial begin
		clk_i = 1'b0;
		forever #2 clk_i = ~clk_i;
	end
	// big-endian byte i of the packed x, y, z results
	function automatic logic [7:0] res_byte(input logic [95:0] r, input int i);
		return r[95 - 8 * i -: 8];
	endfunction
	// plain storage addresses, clear of control and result registers
	function automatic logic [6:0] rand_vaddr();
		return 7'h30 + 7'($urandom % 16);
	endfunction
	task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic end_sim();
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	// one virtual access: request for one cycle, then wait for the done pulse
	task automatic vacc(input logic wr, input logic [6:0] va, input logic [7:0] wd, output logic [7:0] rd);
		int n;
		@(posedge clk_i);
		#1;
		req_i   = 1'b1;
		wr_i    = wr;
		vaddr_i = va;
		wdata_i = wd;
		@(posedge clk_i);
		#1;
		req_i = 1'b0;
		n = 0;
		do begin
			@(posedge clk_i);
			#1;
			n++;
		end while (done_o !== 1'b1 && n < WAIT_MAX);
		if (n >= WAIT_MAX) begin
			n_fail++;
			$display("[ERR] access wait ran out");
		end
		rd = rdata_o;
		chk("nack", {7'h00, nack_o}, 8'h00);
	endtask
	// one-cycle event strobe, results held afterwards, then a few cycles to settle
	task automatic pulse_ev(input bit conv, input logic [95:0] r);
		@(posedge clk_i);
		#1;
		conv_done_i = conv;
		dir_rdy_i   = ~conv;
		conv_res_i  = r;
		@(posedge clk_i);
		#1;
		conv_done_i = 1'b0;
		dir_rdy_i   = 1'b0;
		repeat (4) @(posedge clk_i);
		#1;
	endtask
	// hang guard
	initial begin
		repeat (WATCH) @(posedge clk_i);
		n_fail++;
		end_sim();
	end
	// main sequence
	initial begin
		void'($urandom(32'h83793A50));
		{reset_i, ext_reset_n_i, fast_i} = 3'b111;
		{conv_done_i, dir_rdy_i, req_i, wr_i} = 4'h0;
		conv_res_i = 96'h0;
		vaddr_i = 7'h00;
		wdata_i = 8'h00;
		n_fail = 0;
		checks_done = 0;
		repeat (10) @(posedge clk_i);
		#1;
		reset_i = 1'b0;
		// random virtual write then read back, fast mode
		for (int k = 0; k < 2; k++) begin
			a = rand_vaddr();
			d = 8'($urandom);
			vacc(1'b1, a, d, got);
			vacc(1'b0, a, 8'h00, got);
			chk("vreg readback", got, d);
		end
		// same register read at standard rate
		fast_i = 1'b0;
		vacc(1'b0, a, 8'h00, got);
		chk("std readback", got, d);
		fast_i = 1'b1;
		// conversion interrupt, shadowed result, release on control read
		vacc(1'b1, VRM_VREG_CONV, 8'h40, got);
		res_a = {$urandom, $urandom, $urandom};
		res_b = ~res_a;
		pulse_ev(1'b1, res_a);
		chk("int after conv", {7'h00, int_n_o}, 8'h00);
		vacc(1'b0, VRM_VREG_RES_LO, 8'h00, got);
		chk("x byte0", got, res_byte(res_a, 0));
		pulse_ev(1'b1, res_b);
		vacc(1'b0, VRM_VREG_RES_LO + 7'h01, 8'h00, got);
		chk("x byte1 shadow", got, res_byte(res_a, 1));
		chk("int before ctrl read", {7'h00, int_n_o}, 8'h00);
		vacc(1'b0, VRM_VREG_CONV, 8'h00, got);
		chk("conv ctrl", got & 8'h42, 8'h40);
		chk("int released conv", {7'h00, int_n_o}, 8'h01);
		// director interrupt
		vacc(1'b1, VRM_VREG_DIR, 8'h10, got);
		pulse_ev(1'b0, res_b);
		chk("int after dir", {7'h00, int_n_o}, 8'h00);
		vacc(1'b0, VRM_VREG_DIR, 8'h00, got);
		chk("dir ctrl", got & 8'h11, 8'h11);
		chk("int released dir", {7'h00, int_n_o}, 8'h01);
		end_sim();
	end
endmodule

//--- tb/vrm_assertions.sv
// Purpose: wire-level checks on the i2c link between host and device ends
// Assumes: one clock, synchronous active-high reset, both ends on one interface
// Notes:   a small decoder tracks start, stop, bit count and direction
`timescale 1ns/1ps
module vrm_assertions
	import vrm_pkg::*;
(
	input wire logic clk_i,    // master clock
	input wire logic reset_i,  // synchronous reset
	input wire logic scl_o,    // host scl level
	input wire logic scl_oe,   // host scl enable
	input wire logic sda_h_oe, // host pulls sda
	input wire logic sda_d_oe, // device pulls sda
	input wire logic scl,      // resolved scl
	input wire logic sda       // resolved sda
);
	localparam int HIGH_MIN = 150; // 0.6 us of scl high
	localparam int LOW_MIN  = 300; // close to a fast-mode half period
	logic        scl_q;   // scl one cycle back
	logic        sda_q;   // sda one cycle back
	logic [3:0]  bit_q;   // scl rises within the byte
	logic        first_q; // byte after a start
	logic        rd_q;    // transfer direction from the address byte
	logic        idle_q;  // bus free between stop and start
	logic [7:0]  byte_q;  // bits shifted in so far
	logic [11:0] hi_q;    // cycles of scl high, saturating
	logic [11:0] lo_q;    // cycles of scl low, saturating
	wire start_w = scl & scl_q & sda_q & ~sda;
	wire stop_w  = scl & scl_q & ~sda_q & sda;
	wire rise_w  = scl & ~scl_q;
	wire ack_w   = rise_w & (bit_q == 4'h8) & ~idle_q;
	wire addr_w  = first_q & (bit_q < 4'h8) & ~idle_q;
	// edge history and phase counters, saturate so long idle periods never wrap
	always_ff @(posedge clk_i) begin
		scl_q <= scl;
		sda_q <= sda;
		hi_q  <= (reset_i | ~(scl & scl_q)) ? 12'h000 : hi_q + {11'h000, hi_q != 12'hFFF};
		lo_q  <= (reset_i | (scl | scl_q)) ? 12'h000 : lo_q + {11'h000, lo_q != 12'hFFF};
	end
	// frame decoder: a start opens an address byte, the ninth rise closes a byte
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			bit_q   <= 4'h0;
			first_q <= 1'b0;
			rd_q    <= 1'b0;
			idle_q  <= 1'b1;
		end else if (start_w) begin
			bit_q   <= 4'h0;
			first_q <= 1'b1;
			idle_q  <= 1'b0;
		end else if (stop_w) begin
			idle_q  <= 1'b1;
		end else if (rise_w & ~idle_q) begin
			bit_q   <= (bit_q == 4'h8) ? 4'h0 : bit_q + 4'h1;
			byte_q  <= (bit_q == 4'h8) ? byte_q : {byte_q[6:0], sda};
			first_q <= (bit_q == 4'h8) ? 1'b0 : first_q;
			rd_q    <= (bit_q == 4'h8 && first_q) ? byte_q[0] : rd_q;
		end
	end
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (reset_i);
	sequence s_addr_match;
		ack_w && first_q && byte_q[7:1] == VRM_SLAVE_ADDR;
	endsequence
	sequence s_data_in;
		ack_w && !first_q && !rd_q;
	endsequence
	chk_rst_release: assert property ($fell(reset_i) |-> !sda_d_oe)
		else $error("device drives sda right after reset");
	chk_dev_scl_high: assert property (scl && scl_q |-> $stable(sda_d_oe))
		else $error("device moved sda while scl high");
	chk_addr_ack: assert property (s_addr_match |-> sda_d_oe)
		else $error("device missed ack of its address");
	chk_addr_quiet: assert property (addr_w |-> !sda_d_oe)
		else $error("device drives sda during address bits");
	chk_data_ack: assert property (s_data_in |-> sda_d_oe)
		else $error("device missed ack of a written byte");
	chk_read_single: assert property (ack_w && !first_q && rd_q |-> sda)
		else $error("read byte not closed by a nack");
	chk_idle_quiet: assert property (idle_q |-> !sda_d_oe)
		else $error("device drives sda on a free bus");
	chk_scl_high_min: assert property ($fell(scl) |-> hi_q >= HIGH_MIN)
		else $error("scl high phase too short");
	chk_scl_low_min: assert property ($rose(scl) |-> lo_q >= LOW_MIN)
		else $error("scl low phase too short");
	chk_ack_host_free: assert property (ack_w |-> !sda_h_oe)
		else $error("host holds sda in an ack slot");
	chk_scl_open_drain: assert property (scl_oe |-> !scl_o)
		else $error("host enables scl while driving it high");
endmodule
